// file: core/supply_supervisor_boot_sequencer.sv
// Supply supervisor, option byte loader, level detector, regulator and boot select.
// Assumes comparator and pin inputs are asynchronous; processor on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"
module supply_supervisor_boot_sequencer (
   input wire logic ref_clk, // 100 MHz clock
   input wire logic rst, // Sync reset, active high
   input wire logic ce, // Clock enable
   input wire logic por_ok, // Supply above power-on/down threshold
   input wire logic [4:0] brown_ok, // Supply above each brownout threshold
   input wire logic [6:0] lvl_above, // Supply above each detector level
   input wire logic boot_select_pin, // Boot select pin
   input wire logic [7:0] opt_data, // Option byte from storage
   input wire logic [2:0] power_mode, // Requested power mode
   input wire logic [`N_PERIPH-1:0] osc_req, // Fast oscillator requests
   input wire logic [3:0] addr, // Register address
   input wire logic [31:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [31:0] rdata, // Read data
   output logic chip_reset, // Internal reset to core
   output logic [1:0] boot_src, // Latched boot source
   output logic [1:0] regulator_mode, // Regulator mode
   output logic vref_on, // Internal voltage reference enable
   output logic standby_domain_only, // Kernel domain powered down
   output logic lvl_irq, // Level detector interrupt
   output logic opt_load_req, // Option byte read request
   output logic osc_on, // Fast oscillator enable
   output logic [`N_PERIPH-1:0] osc_gate // Oscillator gates
);
   supervisor_pkg::seq_state_t state_reg, state_next;
   logic por_s, boot_pin_s;
   logic [4:0] brn_s;
   logic [6:0] lvl_s;
   logic [7:0] opt_reg;
   logic opt_valid_reg;
   logic [7:0] cnt_reg;
   logic [31:0] ctrl_reg;
   logic [1:0] stat_reg;
   logic above_reg;
   logic [1:0] boot_reg;
   logic [2:0] brn_sel;
   logic brn_good, supply_good, above_now, rise_ev, fall_ev;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   sync2 #(.W(14)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .d({por_ok, brown_ok, lvl_above, boot_select_pin}),
      .q({por_s, brn_s, lvl_s, boot_pin_s})
   );

   // Pick one comparator from a level field
   function automatic logic pick(input logic [6:0] v, input logic [2:0] i);
      pick = v[i];
   endfunction

   // ****************************************************************
   // Supply good decode
   // ****************************************************************
   // Before option bytes load, the lowest brownout threshold guards start-up
   assign brn_sel = opt_valid_reg ? opt_reg[`OPT_BRN_HI:`OPT_BRN_LO] : 3'h0;
   assign brn_good = (brn_sel >= `BRN_LEVELS) ? brn_s[0] : pick({2'h0, brn_s}, brn_sel); // see R3
   assign supply_good = por_s && (brn_good || (opt_valid_reg && opt_reg[`OPT_BRN_DIS])); // see R1

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         supervisor_pkg::ST_RESET:
            if (supply_good) state_next = supervisor_pkg::ST_LOAD; // see R2
         supervisor_pkg::ST_LOAD:
            if (!supply_good) state_next = supervisor_pkg::ST_RESET;
            else if (cnt_reg == 8'(`OPT_LOAD_CYC)) state_next = supervisor_pkg::ST_RUN; // see R11
         supervisor_pkg::ST_RUN:
            if (!supply_good) state_next = supervisor_pkg::ST_RESET; // see R1
         default: state_next = supervisor_pkg::ST_RESET;
      endcase
   end

   // State and load counter
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= supervisor_pkg::ST_RESET;
         cnt_reg <= 8'h00;
      end else if (ce) begin
         state_reg <= state_next;
         cnt_reg <= (state_reg == supervisor_pkg::ST_LOAD) ? cnt_reg + 8'h01 : 8'h00;
      end
   end

   // Option bytes taken at end of load; kept across brownout dips
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         opt_reg <= 8'h00;
         opt_valid_reg <= 1'b0;
      end else if (ce && state_reg == supervisor_pkg::ST_LOAD
                   && state_next == supervisor_pkg::ST_RUN) begin
         opt_reg <= opt_data; // see R2
         opt_valid_reg <= 1'b1;
      end
   end

   // Boot selection latched at reset release so it cannot change under code
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         boot_reg <= supervisor_pkg::BOOT_FLASH;
      end else if (ce && state_reg == supervisor_pkg::ST_LOAD
                   && state_next == supervisor_pkg::ST_RUN) begin
         if (!boot_pin_s) boot_reg <= supervisor_pkg::BOOT_FLASH; // see R9
         else if (opt_data[`OPT_BOOT_BIT]) boot_reg <= supervisor_pkg::BOOT_SYSTEM; // see R9
         else boot_reg <= supervisor_pkg::BOOT_RAM; // see R11
      end
   end

   // ****************************************************************
   // Level detector
   // ****************************************************************
   assign above_now = (ctrl_reg[`CTRL_LVL_HI:`CTRL_LVL_LO] < `LVL_LEVELS)
      ? pick(lvl_s, ctrl_reg[`CTRL_LVL_HI:`CTRL_LVL_LO]) : lvl_s[6]; // see R5
   assign rise_ev = ctrl_reg[`CTRL_LVL_EN] && above_now && !above_reg;
   assign fall_ev = ctrl_reg[`CTRL_LVL_EN] && !above_now && above_reg;

   // Sticky event flags; a new event beats a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         above_reg <= 1'b0;
         stat_reg <= 2'h0;
      end else if (ce) begin
         above_reg <= above_now;
         stat_reg[`STAT_FALL] <= fall_ev
            || (stat_reg[`STAT_FALL] && !(wr && addr == `REG_STATUS && wdata[`STAT_FALL]));
         stat_reg[`STAT_RISE] <= rise_ev
            || (stat_reg[`STAT_RISE] && !(wr && addr == `REG_STATUS && wdata[`STAT_RISE]));
      end
   end
   assign lvl_irq = (stat_reg[`STAT_FALL] && ctrl_reg[`CTRL_IRQ_FALL])
      || (stat_reg[`STAT_RISE] && ctrl_reg[`CTRL_IRQ_RISE]); // see R6

   // ****************************************************************
   // Register port
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_reg <= `CTRL_RESET;
         rdata <= 32'h0;
      end else if (ce) begin
         if (wr && addr == `REG_CTRL) ctrl_reg <= {25'h0, wdata[6:0]};
         if (rd) begin
            case (addr)
               `REG_CTRL: rdata <= ctrl_reg;
               `REG_STATUS: rdata <= {29'h0, above_reg, stat_reg};
               `REG_PWRMODE: rdata <= {28'h0, regulator_mode, vref_on, standby_domain_only};
               `REG_OPT: rdata <= {23'h0, opt_valid_reg, opt_reg};
               default: rdata <= 32'h0;
            endcase
         end else begin
            rdata <= 32'h0;
         end
      end
   end

   // ****************************************************************
   // Outputs: reset, regulator, reference
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         chip_reset <= 1'b1;
         regulator_mode <= supervisor_pkg::REG_MAIN;
         vref_on <= 1'b1;
         standby_domain_only <= 1'b0;
      end else if (ce) begin
         chip_reset <= (state_next != supervisor_pkg::ST_RUN); // see R1
         case (power_mode)
            supervisor_pkg::PM_RUN, supervisor_pkg::PM_SLEEP:
               regulator_mode <= supervisor_pkg::REG_MAIN; // see R7
            supervisor_pkg::PM_STANDBY: regulator_mode <= supervisor_pkg::REG_DOWN; // see R7
            default: regulator_mode <= supervisor_pkg::REG_LOWPOWER; // see R7
         endcase
         standby_domain_only <= (power_mode == supervisor_pkg::PM_STANDBY); // see R8
         vref_on <= !((power_mode == supervisor_pkg::PM_STOP && ctrl_reg[`CTRL_VREF_AUTO])
            || power_mode == supervisor_pkg::PM_STANDBY); // see R4
      end
   end
   assign opt_load_req = (state_reg == supervisor_pkg::ST_LOAD); // see R2
   assign boot_src = boot_reg;

   osc_grant u_osc (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .osc_req(osc_req),
      .osc_on(osc_on),
      .osc_gate(osc_gate)
   );

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_hold_reset;
      @(posedge ref_clk) disable iff (rst) ce && !supply_good |=> chip_reset;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("reset released at low supply"); // see R1
   property p_load_before_run;
      @(posedge ref_clk) disable iff (rst) $fell(chip_reset) |-> $past(opt_load_req);
   endproperty
   a_load_before_run: assert property (p_load_before_run) else $error("reset released early"); // see R11
   property p_boot_stable;
      @(posedge ref_clk) disable iff (rst) !chip_reset && $past(!chip_reset) |-> $stable(boot_src);
   endproperty
   a_boot_stable: assert property (p_boot_stable) else $error("boot source changed"); // see R11
   property p_boot_flash;
      @(posedge ref_clk) disable iff (rst) $fell(chip_reset) && !$past(boot_pin_s)
         |-> boot_src == supervisor_pkg::BOOT_FLASH;
   endproperty
   a_boot_flash: assert property (p_boot_flash) else $error("boot pin ignored"); // see R9
   property p_standby_reg;
      @(posedge ref_clk) disable iff (rst)
         ce && power_mode == supervisor_pkg::PM_STANDBY |=> regulator_mode == supervisor_pkg::REG_DOWN;
   endproperty
   a_standby_reg: assert property (p_standby_reg) else $error("regulator not down"); // see R7
   property p_run_reg;
      @(posedge ref_clk) disable iff (rst)
         ce && power_mode == supervisor_pkg::PM_RUN |=> regulator_mode == supervisor_pkg::REG_MAIN;
   endproperty
   a_run_reg: assert property (p_run_reg) else $error("regulator not main"); // see R7
   property p_vref_stop;
      @(posedge ref_clk) disable iff (rst) ce && power_mode == supervisor_pkg::PM_STOP
         && ctrl_reg[`CTRL_VREF_AUTO] |=> !vref_on;
   endproperty
   a_vref_stop: assert property (p_vref_stop) else $error("reference left on in Stop"); // see R4
   property p_fall_flag;
      @(posedge ref_clk) disable iff (rst) ce && fall_ev |=> stat_reg[`STAT_FALL];
   endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("falling crossing lost"); // see R6
   property p_standby_dom;
      @(posedge ref_clk) disable iff (rst)
         ce && power_mode == supervisor_pkg::PM_STANDBY |=> standby_domain_only;
   endproperty
   a_standby_dom: assert property (p_standby_dom) else $error("kernel not powered down"); // see R8
   // ****************************************************************
   // Start-up, boot, mode and level detector checks
   // ****************************************************************
   // Core must never run on default options
   property p_opt_loaded;
      @(posedge ref_clk) disable iff (rst) $fell(chip_reset) |-> opt_valid_reg;
   endproperty
   a_opt_loaded: assert property (p_opt_loaded) else $error("options not loaded"); // see R2
   // Load state ends no later than when the counter reaches its end point, so the load never overruns
   property p_load_len;
      @(posedge ref_clk) disable iff (rst)
         opt_load_req |-> cnt_reg <= 8'(`OPT_LOAD_CYC);
   endproperty
   a_load_len: assert property (p_load_len) else $error("option load overran"); // see R11
   // Pin high with the option bit set boots system memory
   property p_boot_system;
      @(posedge ref_clk) disable iff (rst) $fell(chip_reset) && $past(boot_pin_s)
         && opt_reg[`OPT_BOOT_BIT] |-> boot_src == supervisor_pkg::BOOT_SYSTEM;
   endproperty
   a_boot_system: assert property (p_boot_system) else $error("system boot missed"); // see R9
   // Pin high with the option bit clear boots RAM
   property p_boot_ram;
      @(posedge ref_clk) disable iff (rst) $fell(chip_reset) && $past(boot_pin_s)
         && !opt_reg[`OPT_BOOT_BIT] |-> boot_src == supervisor_pkg::BOOT_RAM;
   endproperty
   a_boot_ram: assert property (p_boot_ram) else $error("RAM boot missed"); // see R9
   // Low-power run, low-power sleep and Stop share the low-power regulator
   property p_lowpower_reg;
      @(posedge ref_clk) disable iff (rst) ce && (power_mode == supervisor_pkg::PM_LPRUN
         || power_mode == supervisor_pkg::PM_LPSLEEP || power_mode == supervisor_pkg::PM_STOP)
         |=> regulator_mode == supervisor_pkg::REG_LOWPOWER;
   endproperty
   a_lowpower_reg: assert property (p_lowpower_reg) else $error("not low power"); // see R7
   // Outside Stop and Standby the reference stays on
   property p_vref_run;
      @(posedge ref_clk) disable iff (rst)
         ce && power_mode == supervisor_pkg::PM_RUN |=> vref_on;
   endproperty
   a_vref_run: assert property (p_vref_run) else $error("reference off in Run"); // see R4
   // Standby removes the reference together with the kernel supply
   property p_vref_standby;
      @(posedge ref_clk) disable iff (rst)
         ce && power_mode == supervisor_pkg::PM_STANDBY |=> !vref_on;
   endproperty
   a_vref_standby: assert property (p_vref_standby) else $error("reference on in Standby"); // see R8
   property p_rise_flag;
      @(posedge ref_clk) disable iff (rst) ce && rise_ev |=> stat_reg[`STAT_RISE];
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("rising crossing lost"); // see R6
   // An enabled flag reaches the interrupt unless software masks it at once
   property p_fall_irq;
      @(posedge ref_clk) disable iff (rst) ce && fall_ev && ctrl_reg[`CTRL_IRQ_FALL]
         && !(wr && addr == `REG_CTRL) |=> lvl_irq;
   endproperty
   a_fall_irq: assert property (p_fall_irq) else $error("falling interrupt lost"); // see R6
   // Main scenarios worth seeing at least once
   c_release: cover property (@(posedge ref_clk) disable iff (rst) $fell(chip_reset));
   c_rise_irq: cover property (@(posedge ref_clk) disable iff (rst) rise_ev ##1 lvl_irq);
   c_brownout: cover property (@(posedge ref_clk) disable iff (rst) !chip_reset ##1 !supply_good);
   c_boot_ram: cover property (@(posedge ref_clk) disable iff (rst)
      $fell(chip_reset) && boot_src == supervisor_pkg::BOOT_RAM);
   c_standby: cover property (@(posedge ref_clk) disable iff (rst)
      regulator_mode == supervisor_pkg::REG_DOWN);
endmodule // supply_supervisor_boot_sequencer
`default_nettype wire

// file: core/supervisor_defines.svh
// Constants and rule summary for the supply supervisor and boot sequencer.
// Assumes inclusion by bare name from core/ sources; holds definitions only.
//
// What this block does
// R1: Hold chip reset while supply is below power-on/down or brownout threshold.
// R2: Past start threshold (1.8 V or 1.65 V), load option bytes, may disable brownout.
// R3: Brownout supervisor offers five option-byte thresholds from 1.8 V to 3 V.
// R4: Optional automatic switch-off of internal voltage reference in Stop.
// R5: Software-enabled level detector compares supply against one of seven levels.
// R6: Level detector interrupts on falling, rising or both crossings.
// R7: Main regulation in Run, low-power in low-power modes and Stop, off in Standby.
// R8: Standby loses everything except the standby domain.
// R9: Boot source from boot select pin and option bit: flash, system, RAM.
// R10: Fast oscillator starts on peripheral request, feeds only requesters, stops when idle.
// R11: Release reset only after option bytes load; latch boot choice at release.
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_PWRMODE 4'h8
`define REG_OPT 4'hc

// ****************************************************************
// Field layout
// ****************************************************************
`define CTRL_LVL_EN 0
`define CTRL_LVL_LO 1
`define CTRL_LVL_HI 3
`define CTRL_IRQ_FALL 4
`define CTRL_IRQ_RISE 5
`define CTRL_VREF_AUTO 6
`define CTRL_RESET 32'h0000_0000
`define STAT_FALL 0
`define STAT_RISE 1
`define STAT_ABOVE 2
`define OPT_BRN_LO 0
`define OPT_BRN_HI 2
`define OPT_BRN_DIS 3
`define OPT_BOOT_BIT 4
`define BRN_LEVELS 3'h5
`define LVL_LEVELS 3'h7
`define N_PERIPH 4

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_NS 10
`define OPT_LOAD_NS 200
`define OPT_LOAD_CYC ((`OPT_LOAD_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: core/supervisor_pkg.sv
// Types for the supply supervisor and boot sequencer.
// Assumes no surroundings beyond a SystemVerilog compiler.
package supervisor_pkg;
   typedef enum {ST_RESET, ST_LOAD, ST_RUN} seq_state_t;
   typedef enum logic [1:0] {BOOT_FLASH = 2'h0, BOOT_SYSTEM = 2'h1, BOOT_RAM = 2'h2} boot_t;
   typedef enum logic [2:0] {PM_RUN = 3'h0, PM_SLEEP = 3'h1, PM_LPRUN = 3'h2,
      PM_LPSLEEP = 3'h3, PM_STOP = 3'h4, PM_STANDBY = 3'h5} power_mode_t;
   typedef enum logic [1:0] {REG_MAIN = 2'h0, REG_LOWPOWER = 2'h1, REG_DOWN = 2'h2} reg_mode_t;
endpackage

// file: core/sync2.sv
// Two-flop synchroniser for asynchronous levels.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(parameter int W = 1) (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Sync reset
   input wire logic ce, // Clock enable
   input wire logic [W-1:0] d, // Async input
   output logic [W-1:0] q // Synchronised
);
   logic [W-1:0] meta_reg;
   // ****************************************************************
   // Two stages
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else if (ce) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // sync2
`default_nettype wire

// file: core/osc_grant.sv
// Fast oscillator request arbiter for Stop-wakeup peripherals.
// Assumes requests come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"
module osc_grant (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Sync reset
   input wire logic ce, // Clock enable
   input wire logic [`N_PERIPH-1:0] osc_req, // Per-peripheral request
   output logic osc_on, // Oscillator enable
   output logic [`N_PERIPH-1:0] osc_gate // Per-peripheral clock gate
);
   // ****************************************************************
   // Grant follows requests; oscillator off when nobody asks
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         osc_on <= 1'b0;
         osc_gate <= '0;
      end else if (ce) begin
         osc_on <= |osc_req; // see R10
         osc_gate <= osc_req; // Only requesters fed, see R10
      end
   end
   property p_gate;
      @(posedge ref_clk) disable iff (rst)
         ce |=> osc_gate == $past(osc_req) && osc_on == |$past(osc_req);
   endproperty
   a_gate: assert property (p_gate) else $error("oscillator grant mismatch"); // see R10
   property p_on_grant;
      @(posedge ref_clk) disable iff (rst) osc_on == |osc_gate;
   endproperty
   a_on_grant: assert property (p_on_grant) else $error("oscillator on without grant"); // see R10
endmodule // osc_grant
`default_nettype wire

// file: testbench/supply_model.sv
// Behavioural model of the supply comparators and option byte storage.
// Assumes the bench sets the supply in millivolts on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
   parameter int POR_MV = 1650, // Power-on/down reset level
   parameter int BRN_BASE_MV = 1800, // Lowest brownout threshold
   parameter int BRN_STEP_MV = 300, // Spacing of brownout thresholds
   parameter int LVL_BASE_MV = 1850, // Lowest detector level
   parameter int LVL_STEP_MV = 200 // Spacing of detector levels
) (
   input wire logic [15:0] supply_mv, // Present supply level
   input wire logic [7:0] opt_store, // Programmed option byte
   output logic por_ok, // Above power-on/down level
   output logic [4:0] brown_ok, // Above each brownout threshold
   output logic [6:0] lvl_above, // Above each detector level
   output logic [7:0] opt_data // Option byte as read back
);
   // ************************************************************
   // Comparators
   // ************************************************************
   // Ideal comparators with no hysteresis, so a step always shows a crossing
   always_comb begin
      por_ok = (int'(supply_mv) >= POR_MV);
      for (int i = 0; i < 5; i++) begin
         brown_ok[i] = (int'(supply_mv) >= BRN_BASE_MV + BRN_STEP_MV * i);
      end
      for (int i = 0; i < 7; i++) begin
         lvl_above[i] = (int'(supply_mv) >= LVL_BASE_MV + LVL_STEP_MV * i);
      end
   end
   // Storage always answers; the loader decides when it samples
   assign opt_data = opt_store;
endmodule // supply_model
`default_nettype wire

// file: testbench/tb_supply_supervisor_boot_sequencer.sv
// Self-checking bench for the supply supervisor and boot sequencer.
// Assumes core/ is on the include path and the model in supply_model.sv.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"
module tb_supply_supervisor_boot_sequencer;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] supply_mv = 16'h0000;
   logic [7:0] opt_store = 8'h00;
   logic boot_select_pin = 1'b0;
   logic [2:0] power_mode = 3'h0;
   logic [`N_PERIPH-1:0] osc_req = '0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic por_ok, chip_reset, vref_on, standby_domain_only, lvl_irq, opt_load_req, osc_on;
   logic [4:0] brown_ok;
   logic [6:0] lvl_above;
   logic [7:0] opt_data;
   logic [31:0] rdata;
   logic [1:0] boot_src, regulator_mode;
   logic [`N_PERIPH-1:0] osc_gate;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;

   // ************************************************************
   // Clock, model and design
   // ************************************************************
   always #5 ref_clk = ~ref_clk;
   supply_model model (.supply_mv(supply_mv), .opt_store(opt_store), .por_ok(por_ok),
      .brown_ok(brown_ok), .lvl_above(lvl_above), .opt_data(opt_data));
   supply_supervisor_boot_sequencer dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
      .por_ok(por_ok), .brown_ok(brown_ok), .lvl_above(lvl_above),
      .boot_select_pin(boot_select_pin), .opt_data(opt_data), .power_mode(power_mode),
      .osc_req(osc_req), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .chip_reset(chip_reset), .boot_src(boot_src), .regulator_mode(regulator_mode),
      .vref_on(vref_on), .standby_domain_only(standby_domain_only), .lvl_irq(lvl_irq),
      .opt_load_req(opt_load_req), .osc_on(osc_on), .osc_gate(osc_gate));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Hang guard: the full sequence needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles >= 5000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic set_supply(input logic [15:0] mv);
      @(posedge ref_clk);
      supply_mv <= mv;
   endtask
   // Power down, then up with the given pin and option byte; checks the load length
   task automatic power_up(input logic pin, input logic [7:0] opt, input logic [1:0] exp_boot);
      int loads;
      loads = 0;
      set_supply(16'h0000);
      wait_cyc(8);
      check(chip_reset, 1'b1);
      boot_select_pin <= pin;
      opt_store <= opt;
      set_supply(16'd3300);
      for (int i = 0; i < 200 && chip_reset !== 1'b0; i++) begin
         wait_cyc(1);
         if (opt_load_req === 1'b1) loads++;
         if (opt_load_req === 1'b1) check(chip_reset, 1'b1);
      end
      check(loads, `OPT_LOAD_CYC + 1);
      check(boot_src, exp_boot);
      boot_select_pin <= ~pin;
      wait_cyc(6);
      check(boot_src, exp_boot);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_boot();
      power_up(1'b0, 8'h10, 2'h0);
      power_up(1'b1, 8'h10, 2'h1);
      power_up(1'b1, 8'h00, 2'h2);
   endtask
   // Threshold 2 selected: a dip between thresholds 0 and 2 must reset
   task automatic t_brownout();
      power_up(1'b0, 8'h02, 2'h0);
      set_supply(16'd2200);
      wait_cyc(5);
      check(chip_reset, 1'b1);
      check(opt_load_req, 1'b0);
      power_up(1'b0, 8'h08, 2'h0);
      set_supply(16'd1700);
      wait_cyc(8);
      check(chip_reset, 1'b0);
      set_supply(16'd1600);
      wait_cyc(5);
      check(chip_reset, 1'b1);
   endtask
   // Level 3 sits at 2450 mV; both crossings with both interrupts enabled
   task automatic t_level();
      logic [31:0] d;
      power_up(1'b0, 8'h00, 2'h0);
      reg_write(`REG_CTRL, 32'h0000_0037);
      reg_read(`REG_CTRL, d);
      check(d, 32'h0000_0037);
      reg_read(`REG_STATUS, d);
      check(d, 32'h0000_0004);
      reg_read(`REG_OPT, d);
      check(d, 32'h0000_0100);
      set_supply(16'd2300);
      wait_cyc(5);
      check(lvl_irq, 1'b1);
      reg_read(`REG_STATUS, d);
      check(d, 32'h0000_0001);
      reg_write(`REG_STATUS, 32'h0000_0001);
      wait_cyc(1);
      check(lvl_irq, 1'b0);
      set_supply(16'd3300);
      wait_cyc(5);
      reg_read(`REG_STATUS, d);
      check(d, 32'h0000_0006);
      check(lvl_irq, 1'b1);
      reg_write(`REG_STATUS, 32'h0000_0002);
      reg_read(4'h2, d);
      check(d, 32'h0000_0000);
      check(lvl_irq, 1'b0);
   endtask
   // Regulator, standby domain and reference per mode, auto-off then on
   task automatic t_modes();
      logic [2:0] pm [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
      logic [1:0] rm [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
      logic [31:0] d;
      for (int a = 0; a < 2; a++) begin
         reg_write(`REG_CTRL, a ? 32'h0000_0040 : 32'h0000_0000);
         for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            power_mode <= pm[i];
            wait_cyc(3);
            check(regulator_mode, rm[i]);
            check(standby_domain_only, pm[i] == 3'h5);
            check(vref_on, !(pm[i] == 3'h5 || (a == 1 && pm[i] == 3'h4)));
         end
      end
      reg_read(`REG_PWRMODE, d);
      check(d, 32'h0000_0009);
      @(posedge ref_clk);
      power_mode <= 3'h0;
   endtask
   task automatic t_osc();
      logic [`N_PERIPH-1:0] pat [4] = '{4'h5, 4'ha, 4'h8, 4'h0};
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         osc_req <= pat[i];
         wait_cyc(1);
         check(osc_gate, pat[i]);
         check(osc_on, pat[i] != 4'h0);
      end
   endtask

   initial begin
      wait_cyc(6);
      check(chip_reset, 1'b1);
      check(regulator_mode, 2'h0);
      check(vref_on, 1'b1);
      @(posedge ref_clk);
      rst <= 1'b0;
      t_boot();
      t_brownout();
      t_level();
      t_modes();
      t_osc();
      finish_test();
   end
endmodule // tb_supply_supervisor_boot_sequencer
`default_nettype wire
